// ---- design/fsr_pkg.sv ----
// shared constants and types for the flash status register block
package fsr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and status-write time
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned STATUS_WRITE_NS = 10000;
   // least time, so round up to whole cycles
   localparam int unsigned STATUS_WRITE_CYC =
      (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = $clog2(STATUS_WRITE_CYC + 1);

   ////////////////////////////////////////////////////////////////////////
   // status word bit positions
   localparam int BUSY_BIT  = 0;
   localparam int WEL_BIT   = 1;
   localparam int RANGE_LSB = 2;
   localparam int RANGE_MSB = 4;
   localparam int TB_BIT    = 5;
   localparam int GRAN_BIT  = 6;
   localparam int LOCK_LOW  = 7;
   localparam int LOCK_HIGH = 8;
   localparam int QUAD_BIT  = 9;
   localparam int OTP_BIT   = 10;
   localparam int LAT_BIT   = 11;
   localparam int DRV_LOW   = 12;
   localparam int DRV_HIGH  = 13;
   localparam int INV_BIT   = 14;
   localparam int SUS_BIT   = 15;

   localparam logic [15:0] STATUS_RESET = 16'h0000;
   // bits that a status write may change; busy, latch, suspend excluded
   localparam logic [15:0] WRITABLE_MASK = 16'h7FFC;

   ////////////////////////////////////////////////////////////////////////
   // derived settings
   localparam logic [3:0] DUMMY_SHORT = 4'h4;
   localparam logic [3:0] DUMMY_LONG  = 4'h8;
   localparam logic [6:0] DRIVE_100   = 7'h64;
   localparam logic [6:0] DRIVE_75    = 7'h4B;
   localparam logic [6:0] DRIVE_50    = 7'h32;
   localparam logic [6:0] DRIVE_25    = 7'h19;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      LOCK_SOFT  = 2'b00,
      LOCK_PIN   = 2'b01,
      LOCK_POWER = 2'b10,
      LOCK_OTP   = 2'b11
   } fsr_lock_e;

   typedef enum logic [3:0] {
      CMD_NONE          = 4'h0,
      CMD_READ_STATUS   = 4'h1,
      CMD_WRITE_ENABLE  = 4'h2,
      CMD_WRITE_DISABLE = 4'h3,
      CMD_WRITE_STATUS  = 4'h4,
      CMD_PAGE_PROGRAM  = 4'h5,
      CMD_QUAD_PROGRAM  = 4'h6,
      CMD_ERASE         = 4'h7,
      CMD_SEC_ERASE     = 4'h8,
      CMD_SEC_PROGRAM   = 4'h9,
      CMD_SUSPEND       = 4'hA,
      CMD_RESUME        = 4'hB,
      CMD_DUAL_IO_READ  = 4'hC,
      CMD_QUAD_IO_READ  = 4'hD,
      CMD_QUAD_OTHER    = 4'hE,
      CMD_OTHER         = 4'hF
   } fsr_cmd_e;

   typedef enum logic [1:0] {
      ST_IDLE         = 2'b00,
      ST_STATUS_WRITE = 2'b01,
      ST_ARRAY_OP     = 2'b10
   } fsr_state_e;

endpackage

// ---- design/fsr_write_timer.sv ----
// countdown for the self-timed status write
`timescale 1ns/1ps
module fsr_write_timer (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic start,
   output logic      done
);

   typedef struct packed {
      logic [fsr_pkg::TIMER_W-1:0] count;
      logic                        running;
      logic                        done;
   } fsr_timer_s;

   fsr_timer_s q;
   fsr_timer_s d;

   always_comb begin
      d = q;
      d.done = 1'b0;
      if (start) begin
         d.count   = fsr_pkg::TIMER_W'(fsr_pkg::STATUS_WRITE_CYC - 1);
         d.running = 1'b1;
      end else if (q.running) begin
         if (q.count == '0) begin
            d.running = 1'b0;
            d.done    = 1'b1;
         end else begin
            d.count = q.count - 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;

endmodule

// ---- design/fsr_status_reg.sv ----
// status and configuration register of the serial flash device
//
// Overview of operation
// - busy set during program, erase, status write
// - busy: ignore all but read status
// - operation end clears busy, accepts commands
// - write enable sets write-enable latch
// - latch cleared by reset, disable, writes
// - three-bit protect range, status-writable, default zero
// - top/bottom select: 0 top, 1 bottom
// - granularity select: 1 sectors, 0 blocks
// - invert bit complements chosen protection
// - status write needs latch and lock permission
// - lock mode 00 ignores protect pin
// - lock mode 01 follows protect pin unless four-lane enable set
// - lock mode 10 locks until power cycle
// - lock mode 11 locks forever
// - drive codes select 100/75/50/25 percent
// - suspend sets pause flag, resume clears
// - latency bit picks 4 or 8 dummies
// - otp area lock never returns to 0
// - four-lane enable turns pins into lanes
// - all bits default to zero
// - quad commands need four-lane enable
`timescale 1ns/1ps
module fsr_status_reg (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_kind,
   input  wire logic [15:0] status_wdata,
   input  wire logic        array_done,
   input  wire logic [15:0] nv_word,
   input  wire logic        write_protect_n_pin,
   output logic [15:0]      status_word,
   output logic             cmd_taken,
   output logic             cmd_ignored,
   output logic             nv_commit,
   output logic [3:0]       dummy_cycles,
   output logic [6:0]       drive_pct,
   output logic             pins_as_lanes,
   output logic             otp_area_locked
);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      fsr_pkg::fsr_state_e st;
      logic [15:0]         word;
      logic [15:0]         pend;
      logic                taken;
      logic                ignored;
      logic                commit;
      logic [3:0]          dummy;
      logic [6:0]          drive;
      logic                lanes;
      logic                wp_s1;
      logic                wp_s2;
   } fsr_main_s;
   fsr_main_s           q;
   fsr_main_s           d;
   fsr_pkg::fsr_cmd_e   cmd;
   logic                tmr_start;
   logic                tmr_done;

   assign cmd = fsr_pkg::fsr_cmd_e'(cmd_kind);

   ////////////////////////////////////////////////////////////////////////
   // functions
   // drive code lookup
   function automatic logic [6:0] drive_of(input logic [15:0] w);
      logic [1:0] c;
      c = w[fsr_pkg::DRV_HIGH:fsr_pkg::DRV_LOW];
      case (c)
         2'b00:   drive_of = fsr_pkg::DRIVE_100;
         2'b01:   drive_of = fsr_pkg::DRIVE_75;
         2'b10:   drive_of = fsr_pkg::DRIVE_50;
         default: drive_of = fsr_pkg::DRIVE_25;
      endcase
   endfunction

   function automatic logic [3:0] dummy_of(input logic [15:0] w);
      dummy_of = w[fsr_pkg::LAT_BIT] ? fsr_pkg::DUMMY_LONG
                                      : fsr_pkg::DUMMY_SHORT;
   endfunction

   function automatic logic write_ok(input logic [15:0] w,
                                     input logic        wp_high);
      fsr_pkg::fsr_lock_e m;
      m = fsr_pkg::fsr_lock_e'(w[fsr_pkg::LOCK_HIGH:fsr_pkg::LOCK_LOW]);
      write_ok = 1'b0;
      if (w[fsr_pkg::WEL_BIT]) begin
         case (m)
            fsr_pkg::LOCK_SOFT:  write_ok = 1'b1;
            // pin decides, but not in four-lane mode
            fsr_pkg::LOCK_PIN:
               write_ok = wp_high | w[fsr_pkg::QUAD_BIT];
            fsr_pkg::LOCK_POWER: write_ok = 1'b0;
            default:             write_ok = 1'b0;
         endcase
      end
   endfunction

   // new word at the end of a status write
   function automatic logic [15:0] merge(input logic [15:0] old_w,
                                         input logic [15:0] new_w);
      logic [15:0] r;
      r = (old_w & ~fsr_pkg::WRITABLE_MASK)
        | (new_w & fsr_pkg::WRITABLE_MASK);
      r[fsr_pkg::OTP_BIT] = old_w[fsr_pkg::OTP_BIT] | new_w[fsr_pkg::OTP_BIT];
      r[fsr_pkg::BUSY_BIT] = 1'b0;
      merge = r;
   endfunction

   // power-up value; volatile bits cleared, stored bits reloaded
   function automatic fsr_main_s power_up(input logic [15:0] nv);
      fsr_main_s s;
      s = '0;
      s.st = fsr_pkg::ST_IDLE;
      // nonvolatile image is all zero from the factory
      s.word = (nv & fsr_pkg::WRITABLE_MASK) | fsr_pkg::STATUS_RESET;
      // power-cycle lock reverts to software mode
      if (s.word[fsr_pkg::LOCK_HIGH:fsr_pkg::LOCK_LOW] == 2'b10) begin
         s.word[fsr_pkg::LOCK_HIGH:fsr_pkg::LOCK_LOW] = 2'b00;
      end
      s.dummy = dummy_of(s.word);
      s.drive = drive_of(s.word);
      s.lanes = s.word[fsr_pkg::QUAD_BIT];
      power_up = s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // status-write timer
   fsr_write_timer u_timer (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (tmr_start),
      .done     (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic busy;
      logic write_enable_latch;
      logic quad;
      logic array_ok;
      busy      = q.word[fsr_pkg::BUSY_BIT];
      write_enable_latch       = q.word[fsr_pkg::WEL_BIT];
      quad      = q.word[fsr_pkg::QUAD_BIT];
      array_ok  = 1'b0;
      d         = q;
      d.taken   = 1'b0;
      d.ignored = 1'b0;
      d.commit  = 1'b0;
      d.wp_s1   = write_protect_n_pin;
      d.wp_s2   = q.wp_s1;
      tmr_start = 1'b0;
      case (q.st)
         fsr_pkg::ST_STATUS_WRITE: begin
            if (tmr_done) begin
               // commit only when the write completes
               d.word   = merge(q.word, q.pend);
               d.commit = 1'b1;
               d.st     = fsr_pkg::ST_IDLE;
            end
         end
         fsr_pkg::ST_ARRAY_OP: begin
            if (array_done) begin
               d.word[fsr_pkg::BUSY_BIT] = 1'b0;
               d.st = fsr_pkg::ST_IDLE;
            end
         end
         default: begin
            d.st = fsr_pkg::ST_IDLE;
         end
      endcase
      if (cmd_valid) begin
         if (busy) begin
            // only status reads get through while busy
            d.taken   = (cmd == fsr_pkg::CMD_READ_STATUS);
            d.ignored = (cmd != fsr_pkg::CMD_READ_STATUS);
         end else begin
            d.taken = 1'b1;
            case (cmd)
               fsr_pkg::CMD_WRITE_ENABLE: begin
                  d.word[fsr_pkg::WEL_BIT] = 1'b1;
               end
               fsr_pkg::CMD_WRITE_DISABLE: begin
                  d.word[fsr_pkg::WEL_BIT] = 1'b0;
               end
               fsr_pkg::CMD_WRITE_STATUS: begin
                  // latch and lock mode must allow it
                  if (write_ok(q.word, q.wp_s2)) begin
                     d.pend = status_wdata;
                     d.word[fsr_pkg::BUSY_BIT] = 1'b1;
                     d.word[fsr_pkg::WEL_BIT] = 1'b0;
                     d.st      = fsr_pkg::ST_STATUS_WRITE;
                     tmr_start = 1'b1;
                  end else begin
                     // refused write leaves all bits alone
                     d.taken   = 1'b0;
                     d.ignored = 1'b1;
                  end
               end
               fsr_pkg::CMD_PAGE_PROGRAM,
               fsr_pkg::CMD_ERASE: begin
                  array_ok = write_enable_latch;
               end
               fsr_pkg::CMD_QUAD_PROGRAM: begin
                  array_ok = write_enable_latch & quad;
               end
               fsr_pkg::CMD_SEC_ERASE,
               fsr_pkg::CMD_SEC_PROGRAM: begin
                  array_ok = write_enable_latch & ~q.word[fsr_pkg::OTP_BIT];
               end
               fsr_pkg::CMD_SUSPEND: begin
                  d.word[fsr_pkg::SUS_BIT] = 1'b1;
               end
               fsr_pkg::CMD_RESUME: begin
                  d.word[fsr_pkg::SUS_BIT] = 1'b0;
               end
               fsr_pkg::CMD_QUAD_IO_READ,
               fsr_pkg::CMD_QUAD_OTHER: begin
                  if (!quad) begin
                     d.taken   = 1'b0;
                     d.ignored = 1'b1;
                  end
               end
               fsr_pkg::CMD_NONE: begin
                  d.taken = 1'b0;
               end
               default: begin
                  d.taken = 1'b1;
               end
            endcase
            if (cmd == fsr_pkg::CMD_PAGE_PROGRAM ||
                cmd == fsr_pkg::CMD_QUAD_PROGRAM ||
                cmd == fsr_pkg::CMD_ERASE ||
                cmd == fsr_pkg::CMD_SEC_ERASE ||
                cmd == fsr_pkg::CMD_SEC_PROGRAM) begin
               if (array_ok) begin
                  // busy until the array reports done
                  d.word[fsr_pkg::BUSY_BIT] = 1'b1;
                  d.word[fsr_pkg::WEL_BIT] = 1'b0;
                  d.st = fsr_pkg::ST_ARRAY_OP;
               end else begin
                  d.taken   = 1'b0;
                  d.ignored = 1'b1;
               end
            end
         end
      end
      // settings follow the next word so outputs stay in step
      d.dummy = dummy_of(d.word);
      d.drive = drive_of(d.word);
      d.lanes = d.word[fsr_pkg::QUAD_BIT];
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         q <= power_up(nv_word);
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign status_word     = q.word;
   assign cmd_taken       = q.taken;
   assign cmd_ignored     = q.ignored;
   assign nv_commit       = q.commit;
   assign dummy_cycles    = q.dummy;
   assign drive_pct       = q.drive;
   assign pins_as_lanes   = q.lanes;
   assign otp_area_locked = q.word[fsr_pkg::OTP_BIT];

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   a_busy_during_op:
   assert property (q.st != fsr_pkg::ST_IDLE |-> status_word[0])
      else $error("busy low while operation runs");
   a_busy_ignores:
   assert property (cmd_valid && status_word[0] &&
                    cmd != fsr_pkg::CMD_READ_STATUS
                    |=> cmd_ignored && !cmd_taken)
      else $error("command accepted while busy");
   a_busy_clears:
   assert property (q.st == fsr_pkg::ST_ARRAY_OP && array_done
                    |=> !status_word[0] && q.st == fsr_pkg::ST_IDLE)
      else $error("busy not cleared at array done");
   a_latch_sets:
   assert property (cmd_valid && !status_word[0] &&
                    cmd == fsr_pkg::CMD_WRITE_ENABLE |=> status_word[1])
      else $error("write enable did not set latch");
   a_latch_clears:
   assert property (cmd_valid && !status_word[0] &&
                    cmd == fsr_pkg::CMD_WRITE_DISABLE |=> !status_word[1])
      else $error("write disable did not clear latch");
   a_pin_lock:
   assert property (cmd_valid && !status_word[0] &&
                    cmd == fsr_pkg::CMD_WRITE_STATUS &&
                    status_word[8:7] == 2'b01 && !q.wp_s2 &&
                    !status_word[9]
                    |=> cmd_ignored && $stable(status_word))
      else $error("status write taken with protect pin low");
   a_lock_refuse:
   assert property (cmd_valid && !status_word[0] &&
                    cmd == fsr_pkg::CMD_WRITE_STATUS &&
                    status_word[8]
                    |=> cmd_ignored ##1 !nv_commit)
      else $error("status write taken while locked");
   a_refused_quiet:
   assert property (cmd_valid && !status_word[0] &&
                    cmd == fsr_pkg::CMD_WRITE_STATUS && !status_word[1]
                    |=> $stable(status_word) && !status_word[0])
      else $error("refused status write changed bits");
   a_commit_hold:
   assert property (q.st == fsr_pkg::ST_STATUS_WRITE && !tmr_done
                    |=> $stable(status_word[15:2]) && status_word[0])
      else $error("status bits moved before commit");
   a_commit_end:
   assert property (q.st == fsr_pkg::ST_STATUS_WRITE && tmr_done
                    |=> nv_commit && !status_word[0])
      else $error("status write end not committed");
   a_otp_sticky:
   assert property ($past(status_word[10]) |-> status_word[10])
      else $error("otp area lock returned to zero");
   a_dummy_count:
   assert property (dummy_cycles == (status_word[11] ? fsr_pkg::DUMMY_LONG
                                                     : fsr_pkg::DUMMY_SHORT))
      else $error("dummy count does not match latency bit");
   a_suspend_flag:
   assert property (cmd_valid && !status_word[0] &&
                    cmd == fsr_pkg::CMD_SUSPEND |=> status_word[15])
      else $error("suspend did not set pause flag");
   a_quad_refuse:
   assert property (cmd_valid && !status_word[0] && !status_word[9] &&
                    cmd == fsr_pkg::CMD_QUAD_IO_READ |=> cmd_ignored)
      else $error("quad read taken without four-lane enable");
endmodule

// ---- dv/fsr_host_model.sv ----
// host-side model: issues decoded commands and plays the array engine
`timescale 1ns/1ps
module fsr_host_model (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        cmd_taken,
   output logic             cmd_valid,
   output logic [3:0]       cmd_kind,
   output logic [15:0]      status_wdata,
   output logic             array_done
);
   // slow or prompt array engine, set by the bench per operation
   int unsigned array_wait = 3;
   int unsigned count_q    = 0;
   logic [3:0]  last_kind  = fsr_pkg::CMD_NONE;

   initial begin
      cmd_valid    = 1'b0;
      cmd_kind     = fsr_pkg::CMD_NONE;
      status_wdata = 16'h0000;
      array_done   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // one command for exactly one edge; released data goes to its inverse
   // so a late sample can never look right by chance
   task automatic issue(input logic [3:0] kind, input logic [15:0] data);
      last_kind    <= kind;
      cmd_valid    <= 1'b1;
      cmd_kind     <= kind;
      status_wdata <= data;
      @(posedge core_clk);
      cmd_valid    <= 1'b0;
      cmd_kind     <= fsr_pkg::CMD_NONE;
      status_wdata <= ~data;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // accepted array op finishes after array_wait cycles
   always @(posedge core_clk) begin
      array_done <= 1'b0;
      if (reset) begin
         count_q <= 0;
      end else if (cmd_taken && last_kind >= fsr_pkg::CMD_PAGE_PROGRAM &&
                   last_kind <= fsr_pkg::CMD_SEC_PROGRAM) begin
         count_q <= array_wait;
      end else if (count_q == 1) begin
         array_done <= 1'b1;
         count_q    <= 0;
      end else if (count_q > 1) begin
         count_q <= count_q - 1;
      end
   end
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the flash status register
`timescale 1ns/1ps
module testbench;
   logic        core_clk;
   logic        reset;
   logic [15:0] nv_word;
   logic        write_protect_n_pin;
   logic        cmd_valid;
   logic [3:0]  cmd_kind;
   logic [15:0] status_wdata;
   logic        array_done;
   logic [15:0] status_word;
   logic        cmd_taken;
   logic        cmd_ignored;
   logic        nv_commit;
   logic [3:0]  dummy_cycles;
   logic [6:0]  drive_pct;
   logic        pins_as_lanes;
   logic        otp_area_locked;
   logic [15:0] sw_ans;
   int          failures    = 0;
   int          comparisons = 0;
   int          cyc         = 0;
   int          t_ans;

   fsr_status_reg uut (
      .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .status_wdata(status_wdata),
      .array_done(array_done), .nv_word(nv_word),
      .write_protect_n_pin(write_protect_n_pin),
      .status_word(status_word), .cmd_taken(cmd_taken),
      .cmd_ignored(cmd_ignored), .nv_commit(nv_commit),
      .dummy_cycles(dummy_cycles), .drive_pct(drive_pct),
      .pins_as_lanes(pins_as_lanes), .otp_area_locked(otp_area_locked)
   );

   fsr_host_model host (
      .core_clk(core_clk), .reset(reset), .cmd_taken(cmd_taken),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .status_wdata(status_wdata), .array_done(array_done)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // whole run needs about 8240 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic power_cycle(input logic [15:0] image);
      nv_word <= image;
      reset   <= 1'b1;
      repeat (4) @(posedge core_clk);
      reset   <= 1'b0;
      // protect pin needs two edges through its synchroniser
      repeat (3) @(posedge core_clk);
   endtask

   // answer is read 1 ns after the taking edge
   task automatic send(input logic [3:0] k, input logic [15:0] d,
                       input logic take);
      host.issue(k, d);
      #1;
      t_ans  = cyc;
      sw_ans = status_word;
      check("taken", 16'(cmd_taken), 16'(take));
      check("ignored", 16'(cmd_ignored), 16'(!take));
      @(posedge core_clk);
   endtask

   task automatic wstat(input logic [15:0] d, input logic [15:0] exp);
      int t0;
      int bad;
      bad = 0;
      send(fsr_pkg::CMD_WRITE_ENABLE, 16'h0000, 1'b1);
      send(fsr_pkg::CMD_WRITE_STATUS, d, 1'b1);
      t0 = t_ans;
      check("start", {14'h0000, sw_ans[1:0]}, 16'h0001);
      send(fsr_pkg::CMD_WRITE_ENABLE, 16'h0000, 1'b0);
      send(fsr_pkg::CMD_READ_STATUS, 16'h0000, 1'b1);
      do begin
         @(posedge core_clk);
         #1;
         if (nv_commit !== 1'b1 && (status_word[0] !== 1'b1 ||
             status_word[15:2] !== sw_ans[15:2])) bad++;
      end while (nv_commit !== 1'b1 && cyc - t0 < 2000);
      check("commit delay", 16'(cyc - t0),
            16'(fsr_pkg::STATUS_WRITE_CYC + 1));
      check("busy held", 16'(bad), 16'h0000);
      check("word", status_word, exp);
      @(posedge core_clk);
   endtask

   // refused write keeps the word and the latch, never raises busy
   task automatic refuse(input logic [15:0] d, input logic [15:0] exp);
      send(fsr_pkg::CMD_WRITE_ENABLE, 16'h0000, 1'b1);
      send(fsr_pkg::CMD_WRITE_STATUS, d, 1'b0);
      check("refused", sw_ans, exp | 16'h0002);
      send(fsr_pkg::CMD_WRITE_DISABLE, 16'h0000, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      #1;
      check("reset word", status_word, fsr_pkg::STATUS_RESET);
      check("reset dummies", {12'h000, dummy_cycles}, 16'h0004);
      check("reset drive", {9'h000, drive_pct}, 16'h0064);
      @(posedge core_clk);
   endtask

   task automatic t_latch();
      send(fsr_pkg::CMD_WRITE_ENABLE, 16'h0000, 1'b1);
      check("latch set", sw_ans, 16'h0002);
      send(fsr_pkg::CMD_WRITE_DISABLE, 16'h0000, 1'b1);
      check("latch clear", sw_ans, 16'h0000);
      send(fsr_pkg::CMD_WRITE_STATUS, 16'h7FFC, 1'b0);
      check("no latch", sw_ans, 16'h0000);
      send(fsr_pkg::CMD_QUAD_IO_READ, 16'h0000, 1'b0);
      send(fsr_pkg::CMD_PAGE_PROGRAM, 16'h0000, 1'b0);
   endtask

   // every drive code, latency toggled alongside, lanes enabled
   task automatic t_drive();
      logic [15:0] w;
      logic [6:0]  pct [4];
      pct = '{7'h64, 7'h4B, 7'h32, 7'h19};
      for (int c = 0; c < 4; c++) begin
         w = 16'h426C | 16'(c << 12) | 16'(c % 2 << 11);
         wstat(w, w);
         #1;
         check("drive", {9'h000, drive_pct}, {9'h000, pct[c]});
         check("dummies", {12'h000, dummy_cycles},
               (c % 2) ? 16'h0008 : 16'h0004);
         check("lanes", 16'(pins_as_lanes), 16'h0001);
         @(posedge core_clk);
      end
   endtask

   // four-lane enable already set before the quad program
   task automatic t_array();
      int n;
      for (int k = 5; k <= 9; k++) begin
         host.array_wait = (k % 2) ? 3 : 40;
         send(fsr_pkg::CMD_WRITE_ENABLE, 16'h0000, 1'b1);
         send(4'(k), 16'h0000, 1'b1);
         check("op start", sw_ans, 16'h7A6D);
         send(fsr_pkg::CMD_RESUME, 16'h0000, 1'b0);
         n = 0;
         #1;
         while (status_word[0] !== 1'b0 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
         end
         check("op end", status_word, 16'h7A6C);
         @(posedge core_clk);
      end
   endtask

   task automatic t_suspend();
      send(fsr_pkg::CMD_SUSPEND, 16'h0000, 1'b1);
      check("pause set", sw_ans, 16'hFA6C);
      send(fsr_pkg::CMD_RESUME, 16'h0000, 1'b1);
      check("pause clear", sw_ans, 16'h7A6C);
      send(fsr_pkg::CMD_QUAD_IO_READ, 16'h0000, 1'b1);
      send(fsr_pkg::CMD_DUAL_IO_READ, 16'h0000, 1'b1);
      check("read keeps word", sw_ans, 16'h7A6C);
   endtask

   // pin is driven, never tied, while lanes were enabled
   task automatic t_lock();
      write_protect_n_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
      wstat(16'h0080, 16'h0080);
      check("lanes off", 16'(pins_as_lanes), 16'h0000);
      refuse(16'h0000, 16'h0080);
      write_protect_n_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      wstat(16'h0100, 16'h0100);
      refuse(16'h0000, 16'h0100);
      power_cycle(16'h0504);
      #1;
      check("power unlock", status_word, 16'h0404);
      @(posedge core_clk);
      wstat(16'h0000, 16'h0400);
      check("otp lock", 16'(otp_area_locked), 16'h0001);
      send(fsr_pkg::CMD_WRITE_ENABLE, 16'h0000, 1'b1);
      send(fsr_pkg::CMD_SEC_PROGRAM, 16'h0000, 1'b0);
      send(fsr_pkg::CMD_WRITE_DISABLE, 16'h0000, 1'b1);
      wstat(16'h0180, 16'h0580);
      refuse(16'h0000, 16'h0580);
      // stored image keeps the otp lock it was given
      power_cycle(16'h0580);
      refuse(16'h0000, 16'h0580);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset               = 1'b1;
      nv_word             = 16'h0000;
      write_protect_n_pin = 1'b1;
      power_cycle(16'h0000);
      t_reset();
      t_latch();
      t_drive();
      t_array();
      t_suspend();
      t_lock();
      tally_and_finish();
   end
endmodule
